// *** core/sac_ctrl.sv ***
// Sequencer of a 16-bit successive-approximation converter with parallel read port.
// Assumes host pins arrive asynchronously; comparator decision is a pin too.
`timescale 1ns/100ps
// Operation
// - Start from chip-select and read/convert both low, in either order
// - Clear approximation register when conversion starts
// - Ignore start requests while converting
// - Trial bits run MSB down to LSB
// - Comparator decides keep or clear per bit
// - Acquire: autozero closed, input on capacitor
// - Convert: autozero open, capacitor grounded
// - Load full result into output latches
// - Internal timer sequences; no external clock
// - Timing supports 100 ksps throughput
// - Zero crossing codes ffff and 0000
// - Full scale codes 7ffe and 7fff
// - Busy low until outputs updated
// - Bus released when deselected or read/convert low
// - Byte select swaps bus halves
module sac_ctrl #(
   parameter int RES_BITS = sac_pkg::RES_BITS,
   parameter int STEP_CYCLES = sac_pkg::STEP_CYCLES,
   parameter int ACQ_CYCLES = sac_pkg::ACQ_CYCLES,
   parameter int START_CYCLES = sac_pkg::START_CYCLES,
   parameter int LATCH_CYCLES = sac_pkg::LATCH_CYCLES,
   parameter int FIFO_DEPTH = sac_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic chip_sel_n,
   input wire logic read_conv,
   input wire logic byte_sel,
   input wire logic comp_out,
   output logic [15:0] dac_trial,
   output logic autozero_closed,
   output logic sample_to_input,
   output logic hold,
   output logic busy_n,
   output logic [15:0] result_bus_o,
   output logic [15:0] result_bus_oe,
   output logic result_valid,
   output logic [15:0] result_data,
   input wire logic result_ready,
   output logic overflow
);
   typedef enum {ST_ACQ, ST_SETTLE, ST_BIT, ST_LATCH} sac_state_e;

   function automatic logic [15:0] sac_swap(input logic [15:0] w, input logic sw);
      sac_swap = sw ? {w[7:0], w[15:8]} : w;
   endfunction

   initial begin
      if (RES_BITS != 16 || STEP_CYCLES < 3 || STEP_CYCLES > 65535 || ACQ_CYCLES < 1
         || START_CYCLES < 2 || START_CYCLES > 255 || LATCH_CYCLES < 1
         || LATCH_CYCLES > 65535 || FIFO_DEPTH < 2) begin
         $error("sac_ctrl parameters out of range");
      end
   end

   // Start, conversion, latch and acquire must fit one 10 us sample period
   initial begin
      if ((RES_BITS + 1) * STEP_CYCLES + LATCH_CYCLES + ACQ_CYCLES + START_CYCLES + 2
         > 10 * sac_pkg::CLK_MHZ) begin
         $error("sac_ctrl timing misses the sample rate");
      end
   end

   sac_fifo_if #(.WIDTH(16)) fq ();

   sac_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .port(fq.fifo)
   );

   // Pin synchronisers
   logic [1:0] cs_meta;
   logic [1:0] rc_meta;
   logic [1:0] by_meta;
   logic [1:0] cmp_meta;
   logic cs_n;
   logic rc;
   logic bsel;
   logic cmp;
   always_ff @(posedge mclk) begin
      if (reset) begin
         cs_meta <= 2'h3;
         rc_meta <= 2'h3;
         by_meta <= 2'h0;
         cmp_meta <= 2'h0;
      end else begin
         cs_meta <= {cs_meta[0], chip_sel_n};
         rc_meta <= {rc_meta[0], read_conv};
         by_meta <= {by_meta[0], byte_sel};
         cmp_meta <= {cmp_meta[0], comp_out};
      end
   end
   assign cs_n = cs_meta[1];
   assign rc = rc_meta[1];
   assign bsel = by_meta[1];
   assign cmp = cmp_meta[1];

   // Start request: chip-select and read/convert both low, held long enough
   logic start_lvl;
   logic start_armed;
   logic [7:0] low_cnt;
   logic start_req;
   assign start_lvl = !cs_n && !rc;
   always_ff @(posedge mclk) begin
      if (reset || !start_lvl) begin
         low_cnt <= 8'h00;
      end else if (low_cnt != 8'hff) begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   // Request fires once per low pulse when the pulse width is met
   assign start_req = start_lvl && start_armed && (32'(low_cnt) + 1 >= START_CYCLES);

   sac_state_e state;
   logic [15:0] approx_register;
   logic [15:0] trial;
   logic [4:0] bit_idx;
   logic [15:0] step_cnt;
   logic [15:0] out_latch;
   logic start_take;
   logic step_done;

   assign start_take = start_req && state == ST_ACQ;
   assign step_done = 32'(step_cnt) >= STEP_CYCLES - 1;

   always_ff @(posedge mclk) begin
      if (reset || !start_lvl) begin
         start_armed <= 1'b1;
      end else if (start_req) begin
         start_armed <= 1'b0;
      end
   end

   // Internal conversion timer; one step per trial bit
   always_ff @(posedge mclk) begin
      if (reset || state == ST_ACQ || step_done) begin
         step_cnt <= 16'h0000;
      end else begin
         step_cnt <= step_cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= ST_ACQ;
      end else begin
         case (state)
            ST_ACQ: begin
               if (start_take) begin
                  state <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (step_done) begin
                  state <= ST_BIT;
               end
            end
            ST_BIT: begin
               if (step_done && bit_idx == 5'd0) begin
                  state <= ST_LATCH;
               end
            end
            ST_LATCH: begin
               if (32'(step_cnt) >= LATCH_CYCLES - 1 || step_done) begin
                  state <= ST_ACQ;
               end
            end
            default: state <= ST_ACQ;
         endcase
      end
   end

   // Approximation: clear at start, then MSB to LSB trials
   always_ff @(posedge mclk) begin
      if (reset) begin
         approx_register <= 16'h0000;
         trial <= 16'h0000;
         bit_idx <= 5'd15;
      end else if (start_take) begin
         approx_register <= 16'h0000;
         trial <= 16'h0000;
         bit_idx <= 5'd15;
      end else if (state == ST_SETTLE && step_done) begin
         trial <= 16'h8000;
      end else if (state == ST_BIT && step_done) begin
         // Comparator high keeps the trial bit
         if (cmp) begin
            approx_register <= approx_register | trial;
         end
         trial <= trial >> 1;
         if (bit_idx != 5'd0) begin
            bit_idx <= bit_idx - 5'd1;
         end
      end
   end

   // Decisions made in this conversion, for the step-count check
   logic [4:0] decide_cnt;
   always_ff @(posedge mclk) begin
      if (reset || start_take) begin
         decide_cnt <= 5'd0;
      end else if (state == ST_BIT && step_done) begin
         decide_cnt <= decide_cnt + 5'd1;
      end
   end

   // Offset binary inside the array; flip the sign bit for two's complement
   always_ff @(posedge mclk) begin
      if (reset) begin
         out_latch <= sac_pkg::RESULT_RESET;
      end else if (state == ST_BIT && step_done && bit_idx == 5'd0) begin
         out_latch <= (approx_register | (cmp ? trial : 16'h0000)) ^ 16'h8000;
      end
   end

   assign dac_trial = approx_register | trial;
   assign autozero_closed = state == ST_ACQ;
   assign sample_to_input = state == ST_ACQ;
   assign hold = state != ST_ACQ;

   // Busy rises only after the latch has the new word
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_n <= 1'b1;
      end else if (start_take) begin
         busy_n <= 1'b0;
      end else if (state == ST_LATCH && busy_n == 1'b0 && !start_take) begin
         busy_n <= state == ST_LATCH && (32'(step_cnt) >= LATCH_CYCLES - 1 || step_done);
      end
   end

   // Three-state read port
   always_ff @(posedge mclk) begin
      if (reset) begin
         result_bus_o <= 16'h0000;
         result_bus_oe <= 16'h0000;
      end else begin
         result_bus_o <= sac_swap(out_latch, bsel);
         result_bus_oe <= (!cs_n && rc) ? 16'hffff : 16'h0000;
      end
   end

   // Finished word offered for one cycle; a full FIFO drops it
   logic push_pend;
   always_ff @(posedge mclk) begin
      if (reset) begin
         push_pend <= 1'b0;
         overflow <= 1'b0;
      end else begin
         push_pend <= state == ST_BIT && step_done && bit_idx == 5'd0;
         if (push_pend && !fq.in_ready) begin
            overflow <= 1'b1;
         end
      end
   end
   assign fq.in_valid = push_pend;
   assign fq.in_data = out_latch;
   assign fq.out_ready = result_ready;
   assign result_valid = fq.out_valid;
   assign result_data = fq.out_data;

   // Checks
   a_start_clears: assert property (@(posedge mclk) disable iff (reset)
      start_take |=> approx_register == 16'h0000 && state == ST_SETTLE)
      else $error("start did not clear approximation");
   a_no_restart: assert property (@(posedge mclk) disable iff (reset)
      (start_req && state == ST_BIT) |=>
      (state == ST_BIT && trial != 16'h0000) || state == ST_LATCH)
      else $error("conversion restarted");
   a_msb_first: assert property (@(posedge mclk) disable iff (reset)
      (state == ST_SETTLE && step_done) |=> trial == 16'h8000)
      else $error("first trial is not the msb");
   a_trial_order: assert property (@(posedge mclk) disable iff (reset)
      state == ST_BIT |-> trial == (16'h0001 << bit_idx))
      else $error("trial bit out of order");
   a_keep_bit: assert property (@(posedge mclk) disable iff (reset)
      (state == ST_BIT && step_done && cmp && bit_idx != 5'd0) |=>
      (approx_register & $past(trial)) != 16'h0000)
      else $error("kept bit lost");
   a_acq_switches: assert property (@(posedge mclk) disable iff (reset)
      busy_n |-> autozero_closed && sample_to_input)
      else $error("autozero open in acquire");
   a_conv_switches: assert property (@(posedge mclk) disable iff (reset)
      !busy_n |-> !autozero_closed && !sample_to_input)
      else $error("switches closed in convert");
   a_latch_steady: assert property (@(posedge mclk) disable iff (reset)
      state != ST_BIT |=> $stable(out_latch))
      else $error("output latch changed outside the last step");
   a_sign_flip: assert property (@(posedge mclk) disable iff (reset)
      (state == ST_BIT && step_done && bit_idx == 5'd0) |=>
      out_latch[15] == !$past(approx_register[15]))
      else $error("sign bit not inverted");
   a_min_pulse: assert property (@(posedge mclk) disable iff (reset)
      start_take |-> $past(start_lvl, START_CYCLES - 1))
      else $error("start on short pulse");
   a_busy_conv: assert property (@(posedge mclk) disable iff (reset)
      start_take |=> !busy_n)
      else $error("busy not low on start");
   a_busy_after_latch: assert property (@(posedge mclk) disable iff (reset)
      $rose(busy_n) |-> $past(state) == ST_LATCH)
      else $error("busy rose before the latch");
   a_bus_release: assert property (@(posedge mclk) disable iff (reset)
      (cs_n || !rc) |=> result_bus_oe == 16'h0000)
      else $error("bus driven while released");
   a_bus_drive: assert property (@(posedge mclk) disable iff (reset)
      (!cs_n && rc) |=> result_bus_oe == 16'hffff)
      else $error("bus not driven on read");
   a_byte_swap: assert property (@(posedge mclk) disable iff (reset)
      bsel |=> result_bus_o == {$past(out_latch[7:0]), $past(out_latch[15:8])})
      else $error("byte swap wrong");
   a_word_order: assert property (@(posedge mclk) disable iff (reset)
      !bsel |=> result_bus_o == $past(out_latch))
      else $error("word order wrong");
   a_sixteen_steps: assert property (@(posedge mclk) disable iff (reset)
      state == ST_LATCH |-> decide_cnt == 5'd16)
      else $error("decision count not sixteen");
   a_overflow_flag: assert property (@(posedge mclk) disable iff (reset)
      (fq.in_valid && !fq.in_ready) |=> overflow)
      else $error("dropped word not flagged");
   a_overflow_sticky: assert property (@(posedge mclk) disable iff (reset)
      overflow |=> overflow)
      else $error("overflow flag cleared");

   // Main scenarios
   c_fifo_full: cover property (@(posedge mclk) disable iff (reset)
      !fq.in_ready);
   c_overflow: cover property (@(posedge mclk) disable iff (reset)
      $rose(overflow));
   c_conversion: cover property (@(posedge mclk) disable iff (reset)
      state == ST_LATCH ##1 state == ST_ACQ);
   c_swapped_read: cover property (@(posedge mclk) disable iff (reset)
      result_bus_oe == 16'hffff && bsel);
   c_ignored_start: cover property (@(posedge mclk) disable iff (reset)
      start_req && state != ST_ACQ);
endmodule

// *** core/sac_fifo.sv ***
// Result FIFO with registered read data.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps
module sac_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic mclk,
   input wire logic reset,
   sac_fifo_if.fifo port
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [WIDTH-1:0] out_data;
   logic out_valid;
   logic push;
   logic pop;
   logic mem_ne;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end

   assign mem_ne = count != '0;
   // Output register counts toward the depth
   assign port.in_ready = (count + (AW + 1)'(out_valid)) < (AW + 1)'(DEPTH);
   assign push = port.in_valid && port.in_ready;
   assign pop = mem_ne && (!out_valid || port.out_ready);
   assign port.out_valid = out_valid;
   assign port.out_data = out_data;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= port.in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr];
      end else if (port.out_ready) begin
         out_valid <= 1'b0;
      end
   end

   a_fifo_bound: assert property (@(posedge mclk) disable iff (reset)
      count <= (AW + 1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// *** core/sac_fifo_if.sv ***
// Handshake bundle between the sequencer and its result FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface sac_fifo_if #(parameter int WIDTH = 16);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport fifo (input in_valid, input in_data, output in_ready,
      output out_valid, output out_data, input out_ready);
   modport ctrl (output in_valid, output in_data, input in_ready,
      input out_valid, input out_data, output out_ready);
endinterface

// *** core/sac_pkg.sv ***
// Shared constants for the converter sequencer.
// Assumes a 250 MHz system clock on every design file.
package sac_pkg;
   localparam int CLK_MHZ = 250;
   localparam int RES_BITS = 16;
   localparam int T_CONV_NS = 7000;
   localparam int T_ACQ_NS = 2000;
   localparam int T_START_NS = 40;
   localparam int T_LATCH_NS = 220;
   localparam int CONV_CYCLES = (T_CONV_NS * CLK_MHZ) / 1000;
   localparam int STEP_CYCLES = CONV_CYCLES / RES_BITS;
   localparam int ACQ_CYCLES = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam int START_CYCLES = (T_START_NS * CLK_MHZ + 999) / 1000;
   localparam int LATCH_CYCLES = (T_LATCH_NS * CLK_MHZ) / 1000;
   localparam int FIFO_DEPTH = 32;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] MAX_POS_CODE = 16'h7fff;
endpackage

// *** verif/sac_comp_model.sv ***
// Comparator and held input of the converter's analog side, as a behavioural model.
// Assumes the held input is a two's complement code and the array works in offset binary.
`timescale 1ns/100ps
module sac_comp_model (
   input wire logic [15:0] dac_trial,
   input wire logic [15:0] vin_code,
   output logic comp_out
);
   // Keep the trial while it stays at or below the held input
   assign comp_out = (dac_trial <= (vin_code ^ 16'h8000));
endmodule

// *** verif/sar_adc_conversion_control_tb_top.sv ***
// Self-checking bench for the converter sequencer: host pins, bus, result stream.
// Assumes shortened step, acquire and latch counts; comparator comes from the model.
`timescale 1ns/100ps
module sar_adc_conversion_control_tb_top;
   localparam int STEP = 4;
   localparam int ACQ = 20;
   localparam int LATCH = 4;
   logic mclk, reset, chip_sel_n, read_conv, byte_sel, comp_out, result_ready;
   logic [15:0] dac_trial, result_bus_o, result_bus_oe, result_data, vin_code;
   logic autozero_closed, sample_to_input, hold, busy_n, result_valid, overflow;
   logic [15:0] codes [6] = '{16'hffff, 16'h0000, 16'h7ffe, 16'h7fff, 16'h8000, 16'h1234};
   int mismatches = 0;
   int n_compared = 0;

   sac_ctrl #(.STEP_CYCLES(STEP), .ACQ_CYCLES(ACQ), .LATCH_CYCLES(LATCH)) dut (
      .mclk(mclk), .reset(reset), .chip_sel_n(chip_sel_n), .read_conv(read_conv),
      .byte_sel(byte_sel), .comp_out(comp_out), .dac_trial(dac_trial),
      .autozero_closed(autozero_closed), .sample_to_input(sample_to_input), .hold(hold),
      .busy_n(busy_n), .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe),
      .result_valid(result_valid), .result_data(result_data),
      .result_ready(result_ready), .overflow(overflow));

   sac_comp_model model (.dac_trial(dac_trial), .vin_code(vin_code), .comp_out(comp_out));

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wait_busy(input logic level);
      for (int i = 0; i < 400 && busy_n !== level; i++) begin
         tick(1);
      end
      if (busy_n !== level) begin
         check("busy_n wait", 16'(busy_n), 16'(level));
         summarize();
      end
   endtask

   task automatic pop_one(input logic [15:0] exp);
      result_ready = 1'b1;
      for (int i = 0; i < 20 && result_valid !== 1'b1; i++) begin
         tick(1);
      end
      check("fifo valid", 16'(result_valid), 16'h0001);
      if (result_valid !== 1'b1) begin
         summarize();
      end
      check("fifo data", result_data, exp);
      tick(1);
      result_ready = 1'b0;
      tick(1);
   endtask

   // One conversion by either start style, then a word and a swapped read
   task automatic convert(input logic [15:0] code, input bit cs_mode, input bit retrig,
         input bit pop);
      vin_code = code;
      check("acquire phase", 16'({autozero_closed, sample_to_input, hold}), 16'h0006);
      if (cs_mode) begin
         read_conv = 1'b0;
      end else begin
         chip_sel_n = 1'b0;
      end
      tick(1);
      chip_sel_n = 1'b0;
      read_conv = 1'b0;
      tick(14);
      wait_busy(1'b0);
      check("convert phase", 16'({autozero_closed, sample_to_input, hold}), 16'h0001);
      check("bus released", result_bus_oe, 16'h0000);
      for (int i = 0; i < 2 * STEP && dac_trial[15] !== 1'b1; i++) begin
         tick(1);
      end
      check("first trial", dac_trial, 16'h8000);
      if (dac_trial[15] !== 1'b1) begin
         summarize();
      end
      read_conv = 1'b1;
      if (retrig) begin
         tick(3);
         read_conv = 1'b0;
         tick(14);
         check("no restart", 16'(busy_n), 16'h0000);
         read_conv = 1'b1;
         // Past the first conversion's end; a restart would still be busy
         tick(55);
         check("no late restart", 16'(busy_n), 16'h0001);
      end
      wait_busy(1'b1);
      tick(4);
      check("bus enable", result_bus_oe, 16'hffff);
      check("word read", result_bus_o, code);
      byte_sel = 1'b1;
      tick(4);
      check("swapped read", result_bus_o, {code[7:0], code[15:8]});
      byte_sel = 1'b0;
      chip_sel_n = 1'b1;
      tick(4);
      check("deselected", result_bus_oe, 16'h0000);
      if (pop) begin
         pop_one(code);
         tick(2);
         check("single entry", 16'(result_valid), 16'h0000);
      end
      tick(ACQ + 5);
   endtask

   // Combinations that must not start a conversion
   task automatic no_start();
      chip_sel_n = 1'b1;
      read_conv = 1'b0;
      tick(30);
      check("cs high no start", 16'(busy_n), 16'h0001);
      chip_sel_n = 1'b0;
      read_conv = 1'b1;
      tick(30);
      check("read no start", 16'(busy_n), 16'h0001);
      check("read no entry", 16'(result_valid), 16'h0000);
      chip_sel_n = 1'b1;
      tick(2);
   endtask

   // Fill the result FIFO past its depth, then drain it in order
   task automatic fill_drain();
      for (int i = 0; i < 33; i++) begin
         convert(16'(i) ^ 16'h0a50, i[0], 1'b0, 1'b0);
         if (i == 31) begin
            check("no overflow at full", 16'(overflow), 16'h0000);
         end
      end
      check("overflow sticky", 16'(overflow), 16'h0001);
      for (int i = 0; i < 32; i++) begin
         pop_one(16'(i) ^ 16'h0a50);
      end
      tick(2);
      check("drained", 16'(result_valid), 16'h0000);
   endtask

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial begin
      reset = 1'b1;
      chip_sel_n = 1'b1;
      read_conv = 1'b1;
      byte_sel = 1'b0;
      result_ready = 1'b0;
      vin_code = 16'h0000;
      tick(11);
      check("reset busy_n", 16'(busy_n), 16'h0001);
      check("reset oe", result_bus_oe, 16'h0000);
      check("reset bus", result_bus_o, 16'h0000);
      check("reset overflow", 16'(overflow), 16'h0000);
      tick(1);
      reset = 1'b0;
      tick(4);
      no_start();
      for (int k = 0; k < 6; k++) begin
         convert(codes[k], k[0], k == 2, 1'b1);
      end
      fill_drain();
      summarize();
   end
endmodule
